// >>> hw/phy_status_ops_regs.sv
// quick poll detailed status and 10base-t operations registers
`include "phy_regs_consts.svh"
`timescale 1ns/1ps
module phy_status_ops_regs #(
   parameter int RXD_WIDTH = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input phy_regs_pkg::mgmt_req_t mgmt_req,
   output logic [15:0] rd_data_q,
   output logic rd_valid_q,
   output logic vendor_access_q,
   input phy_regs_pkg::core_status_t core_status,
   output phy_regs_pkg::core_ctrl_t core_ctrl_q,
   input wire logic [1:0] bus_mode_strap,
   input wire logic amdix_strap,
   input wire logic rx_tristate_strap,
   input wire logic vendor_gate_strap,
   input wire logic [RXD_WIDTH-1:0] rx_data_core,
   input wire logic rx_dv_core,
   output logic [RXD_WIDTH-1:0] rxd_out_q,
   output logic rx_dv_out_q,
   output logic rx_oe_q,
   output logic link_pass_q
);

   // operations register control bits
   logic amdix_q;
   logic receive_tristate_q;
   logic vendor_reg_access_gate_q;
   logic test_mux_select_q;
   logic jabber_inhibit_q;
   logic polarity_inhibit_q;
   logic sqe_inhibit_q;
   logic link_loss_inhibit_q;
   logic squelch_inhibit_q;
   phy_regs_pkg::bus_mode_t bus_mode_q;

   // latched flags
   logic [`NUM_FLAGS-1:0] flag_cond;
   logic [`NUM_FLAGS-1:0] flag_q;

   // access decode
   wire status_hit = mgmt_req.addr == `STATUS_REG_ADDR;
   wire ops_hit = mgmt_req.addr == `OPS_REG_ADDR;
   wire vendor_hit = mgmt_req.addr >= `VENDOR_FIRST_ADDR;
   wire status_rd = mgmt_req.rd && status_hit;
   wire ops_rd = mgmt_req.rd && ops_hit;
   wire ops_wr = mgmt_req.wr && ops_hit;
   wire vendor_ok = vendor_hit && !vendor_reg_access_gate_q;

   // link is good when valid or when loss detection is inhibited
   wire link_eff = core_status.link_valid || link_loss_inhibit_q;

   // flag conditions, status register flags first
   assign flag_cond[0] = core_status.signal_lost;
   assign flag_cond[1] = core_status.pll_lock_err;
   assign flag_cond[2] = core_status.false_carrier;
   assign flag_cond[3] = core_status.invalid_symbol;
   assign flag_cond[4] = core_status.halt_symbol;
   assign flag_cond[5] = core_status.premature_end;
   assign flag_cond[6] = core_status.jabber && !jabber_inhibit_q;
   assign flag_cond[7] = core_status.remote_fault;
   assign flag_cond[8] = core_status.remote_jabber;
   assign flag_cond[9] = link_eff;

   // status register flags release on status read, operations flags on
   // operations read; three latch_flags instances, each cleared by its group's read
   logic [8:0] st_flag_q;
   logic [1:0] op_flag_q;
   latch_flags #(
      .WIDTH(8),
      .LOW_MASK(8'h00)
   ) u_status_high (
      .clk(clk),
      .sys_rst(sys_rst),
      .rd_clear(status_rd),
      .cond(flag_cond[7:0]),
      .flag_q(st_flag_q[7:0])
   );
   latch_flags #(
      .WIDTH(2),
      .LOW_MASK(2'h0)
   ) u_ops_high (
      .clk(clk),
      .sys_rst(sys_rst),
      .rd_clear(ops_rd),
      .cond(core_status.polarity_reversed ? 2'h2 | {1'b0, flag_cond[8]} :
            {1'b0, flag_cond[8]}),
      .flag_q(op_flag_q)
   );
   latch_flags #(
      .WIDTH(1),
      .LOW_MASK(1'b1)
   ) u_link_low (
      .clk(clk),
      .sys_rst(sys_rst),
      .rd_clear(status_rd),
      .cond(flag_cond[9:9]),
      .flag_q(st_flag_q[8:8])
   );
   assign flag_q = {st_flag_q[8], op_flag_q[0], st_flag_q[7:0]};

   // status register image
   logic [15:0] status_img;
   always_comb begin
      status_img = 16'h0000;
      status_img[`ST_RATE_BIT] = core_status.rate_100;
      status_img[`ST_DUPLEX_BIT] = core_status.full_duplex;
      status_img[`ST_PROG_HI:`ST_PROG_LO] = core_status.an_progress;
      status_img[`ST_SIG_LOST_BIT] = flag_q[0];
      status_img[`ST_PLL_ERR_BIT] = flag_q[1];
      status_img[`ST_FALSE_CAR_BIT] = flag_q[2];
      status_img[`ST_BAD_SYM_BIT] = flag_q[3];
      status_img[`ST_HALT_BIT] = flag_q[4];
      status_img[`ST_PREM_END_BIT] = flag_q[5];
      status_img[`ST_AN_DONE_BIT] = core_status.an_complete;
      status_img[`ST_NO_SIG_BIT] = core_status.no_signal;
      status_img[`ST_JABBER_BIT] = flag_q[6];
      status_img[`ST_RFAULT_BIT] = flag_q[7];
      status_img[`ST_LINK_BIT] = flag_q[9];
   end

   // operations register image; bits 7:6 read zero, bit 4 reads one
   logic [15:0] ops_img;
   always_comb begin
      ops_img = 16'h0000;
      ops_img[`OP_RJAB_BIT] = flag_q[8];
      ops_img[`OP_POLREV_BIT] = op_flag_q[1];
      ops_img[`OP_MODE_HI:`OP_MODE_LO] = bus_mode_q;
      ops_img[`OP_AMDIX_BIT] = amdix_q;
      ops_img[`OP_RECEIVE_TRISTATE_BIT] = receive_tristate_q;
      ops_img[`OP_GATE_BIT] = vendor_reg_access_gate_q;
      ops_img[`OP_TMUX_BIT] = test_mux_select_q;
      ops_img[`OP_JABINH_BIT] = jabber_inhibit_q;
      ops_img[`OP_RSV1_BIT] = `RSV1_VALUE;
      ops_img[`OP_APINH_BIT] = polarity_inhibit_q;
      ops_img[`OP_SQEINH_BIT] = sqe_inhibit_q;
      ops_img[`OP_LLINH_BIT] = link_loss_inhibit_q;
      ops_img[`OP_SQLINH_BIT] = squelch_inhibit_q;
   end

   // read mux; unmapped and denied vendor numbers read zero
   wire [15:0] rd_mux = status_hit ? status_img : (ops_hit ? ops_img : 16'h0000);

   // strapped bus mode, 1x folds to rmii
   wire [1:0] strap_mode = bus_mode_strap[1] ? 2'h2 : bus_mode_strap;

   // operations control bits; straps are caught while reset is held
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_mode_q <= phy_regs_pkg::bus_mode_t'(strap_mode);
         amdix_q <= amdix_strap;
         receive_tristate_q <= rx_tristate_strap;
         vendor_reg_access_gate_q <= vendor_gate_strap;
         test_mux_select_q <= `TMUX_RST;
         jabber_inhibit_q <= `JABINH_RST;
         polarity_inhibit_q <= `APINH_RST;
         sqe_inhibit_q <= `SQEINH_RST;
         link_loss_inhibit_q <= `LLINH_RST;
         squelch_inhibit_q <= `SQLINH_RST;
      end else if (ops_wr) begin
         amdix_q <= mgmt_req.wdata[`OP_AMDIX_BIT];
         receive_tristate_q <= mgmt_req.wdata[`OP_RECEIVE_TRISTATE_BIT];
         vendor_reg_access_gate_q <= mgmt_req.wdata[`OP_GATE_BIT];
         test_mux_select_q <= mgmt_req.wdata[`OP_TMUX_BIT];
         jabber_inhibit_q <= mgmt_req.wdata[`OP_JABINH_BIT];
         polarity_inhibit_q <= mgmt_req.wdata[`OP_APINH_BIT];
         sqe_inhibit_q <= mgmt_req.wdata[`OP_SQEINH_BIT];
         link_loss_inhibit_q <= mgmt_req.wdata[`OP_LLINH_BIT];
         squelch_inhibit_q <= mgmt_req.wdata[`OP_SQLINH_BIT];
      end
   end

   // read answer one cycle after the request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data_q <= 16'h0000;
         rd_valid_q <= 1'b0;
         vendor_access_q <= 1'b0;
      end else begin
         rd_data_q <= mgmt_req.rd ? rd_mux : rd_data_q;
         rd_valid_q <= mgmt_req.rd;
         vendor_access_q <= (mgmt_req.rd || mgmt_req.wr) && vendor_ok;
      end
   end

   // controls to the phy core, registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         core_ctrl_q <= '0;
         link_pass_q <= 1'b0;
      end else begin
         core_ctrl_q.amdix_en <= amdix_q;
         core_ctrl_q.test_mux_select <= test_mux_select_q;
         core_ctrl_q.auto_polarity_en <= !polarity_inhibit_q;
         core_ctrl_q.sqe_test_en <= !sqe_inhibit_q;
         core_ctrl_q.link_forced_pass <= link_loss_inhibit_q;
         core_ctrl_q.jabber_check_en <= !jabber_inhibit_q;
         core_ctrl_q.squelch_en <= !squelch_inhibit_q;
         link_pass_q <= link_eff;
      end
   end

   // receive outputs, released when tri-state is requested
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxd_out_q <= '0;
         rx_dv_out_q <= 1'b0;
         rx_oe_q <= 1'b0;
      end else begin
         rxd_out_q <= rx_data_core;
         rx_dv_out_q <= rx_dv_core;
         rx_oe_q <= !receive_tristate_q;
      end
   end

endmodule

// >>> hw/phy_regs_consts.svh
// offsets, field positions and reset values of the status and operations registers
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH

// register numbers on the management access port
`define STATUS_REG_ADDR 5'h11
`define OPS_REG_ADDR 5'h12
`define VENDOR_FIRST_ADDR 5'h19
`define VENDOR_LAST_ADDR 5'h1F

// quick poll detailed status fields
`define ST_RATE_BIT 15
`define ST_DUPLEX_BIT 14
`define ST_PROG_HI 13
`define ST_PROG_LO 11
`define ST_SIG_LOST_BIT 10
`define ST_PLL_ERR_BIT 9
`define ST_FALSE_CAR_BIT 8
`define ST_BAD_SYM_BIT 7
`define ST_HALT_BIT 6
`define ST_PREM_END_BIT 5
`define ST_AN_DONE_BIT 4
`define ST_NO_SIG_BIT 3
`define ST_JABBER_BIT 2
`define ST_RFAULT_BIT 1
`define ST_LINK_BIT 0

// operations register fields
`define OP_RJAB_BIT 15
`define OP_POLREV_BIT 14
`define OP_MODE_HI 13
`define OP_MODE_LO 12
`define OP_AMDIX_BIT 11
`define OP_RECEIVE_TRISTATE_BIT 10
`define OP_GATE_BIT 9
`define OP_TMUX_BIT 8
`define OP_JABINH_BIT 5
`define OP_RSV1_BIT 4
`define OP_APINH_BIT 3
`define OP_SQEINH_BIT 2
`define OP_LLINH_BIT 1
`define OP_SQLINH_BIT 0

// reset values of the plain control bits, and the fixed value of reserved bit 4
`define TMUX_RST 1'b0
`define JABINH_RST 1'b0
`define APINH_RST 1'b0
`define SQEINH_RST 1'b0
`define LLINH_RST 1'b0
`define SQLINH_RST 1'b0
`define RSV1_VALUE 1'b1

// latched flag vector layout: 0..8 latching high, 9 latching low
`define NUM_FLAGS 10
`define LOW_MASK 10'h200

`endif

// >>> hw/phy_regs_pkg.sv
// types shared by the status and operations register bank
package phy_regs_pkg;

   // one management access, registers at their printed numbers
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } mgmt_req_t;

   // live conditions reported by the phy core
   typedef struct packed {
      logic rate_100;
      logic full_duplex;
      logic [2:0] an_progress;
      logic an_complete;
      logic no_signal;
      logic signal_lost;
      logic pll_lock_err;
      logic false_carrier;
      logic invalid_symbol;
      logic halt_symbol;
      logic premature_end;
      logic jabber;
      logic remote_fault;
      logic remote_jabber;
      logic polarity_reversed;
      logic link_valid;
   } core_status_t;

   // controls steering the phy core
   typedef struct packed {
      logic amdix_en;
      logic test_mux_select;
      logic auto_polarity_en;
      logic sqe_test_en;
      logic link_forced_pass;
      logic jabber_check_en;
      logic squelch_en;
   } core_ctrl_t;

   // data bus modes reported from the strap
   typedef enum logic [1:0] {
      BUS_MII = 2'h0,
      BUS_SERIAL = 2'h1,
      BUS_RMII = 2'h2
   } bus_mode_t;

endpackage

// >>> hw/latch_flags.sv
// latching-high and latching-low status flags, updated on register read
`timescale 1ns/1ps
module latch_flags #(
   parameter int WIDTH = 10,
   parameter logic [WIDTH-1:0] LOW_MASK = '0
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rd_clear,
   input wire logic [WIDTH-1:0] cond,
   output logic [WIDTH-1:0] flag_q
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         logic flag_d;
         // event wins over the read that would release the flag
         if (LOW_MASK[i]) begin : g_low
            assign flag_d = !cond[i] ? 1'b0 : (rd_clear ? 1'b1 : flag_q[i]);
         end else begin : g_high
            assign flag_d = cond[i] ? 1'b1 : (rd_clear ? 1'b0 : flag_q[i]);
         end
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               flag_q[i] <= 1'b0;
            end else begin
               flag_q[i] <= flag_d;
            end
         end
      end
   endgenerate

endmodule

// >>> testbench/phy_status_ops_regs_props.sv
// property checker for the status and operations register bank
`timescale 1ns/1ps
module phy_status_ops_regs_props (
   input wire logic clk,
   input wire logic sys_rst,
   input phy_regs_pkg::mgmt_req_t mgmt_req,
   input wire logic [15:0] rd_data_q,
   input wire logic rd_valid_q,
   input wire logic vendor_access_q,
   input phy_regs_pkg::core_status_t core_status,
   input phy_regs_pkg::core_ctrl_t core_ctrl_q,
   input wire logic rx_oe_q,
   input wire logic link_pass_q,
   input wire logic vendor_gate_strap
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // decoded status reads and operations writes
   wire st_rd = mgmt_req.rd && mgmt_req.addr == 5'h11;
   wire op_wr = mgmt_req.wr && mgmt_req.addr == 5'h12;
   wire [15:0] wd = mgmt_req.wdata;
   // mirror of the vendor gate bit: strap during reset, then writes
   logic gate_m;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gate_m <= vendor_gate_strap;
      end else if (op_wr) begin
         gate_m <= wd[9];
      end
   end
   wire vend_acc = (mgmt_req.rd || mgmt_req.wr) && mgmt_req.addr >= 5'h19;

   chk_read_answer: assert property (rd_valid_q == $past(mgmt_req.rd))
      else $error("read answer not one cycle after request");
   chk_progress_low: assert property (
      st_rd |=> rd_data_q[11] == $past(core_status.an_progress[0]))
      else $error("progress bit 0 wrong");
   chk_false_carrier: assert property (
      core_status.false_carrier ##1 st_rd |=> rd_data_q[8])
      else $error("false carrier flag lost");
   chk_halt_flag: assert property (
      core_status.halt_symbol ##1 st_rd |=> rd_data_q[6])
      else $error("halt flag lost");
   chk_prem_end: assert property (
      core_status.premature_end ##1 st_rd |=> rd_data_q[5])
      else $error("premature end flag lost");
   chk_remote_fault: assert property (
      core_status.remote_fault ##1 st_rd |=> rd_data_q[1])
      else $error("remote fault flag lost");
   chk_rx_tristate: assert property (
      op_wr |-> ##2 rx_oe_q == !$past(wd[10], 2))
      else $error("receive enable wrong");
   chk_vendor_gate: assert property (
      vendor_access_q == ($past(vend_acc) && !$past(gate_m)))
      else $error("vendor access against gate bit");
   chk_tmux_follow: assert property (
      op_wr |-> ##2 core_ctrl_q.test_mux_select == $past(wd[8], 2))
      else $error("test mux select wrong");
   chk_polarity_inh: assert property (
      op_wr |-> ##2 core_ctrl_q.auto_polarity_en != $past(wd[3], 2))
      else $error("auto polarity wrong");
   chk_sqe_inh: assert property (
      op_wr |-> ##2 core_ctrl_q.sqe_test_en != $past(wd[2], 2))
      else $error("sqe test wrong");
   chk_link_force: assert property (op_wr && wd[1] |-> ##2 link_pass_q)
      else $error("forced link pass missing");

   cover property (op_wr);
   cover property (st_rd ##1 rd_data_q[8]);
   cover property (vendor_access_q);
endmodule
bind phy_status_ops_regs phy_status_ops_regs_props u_props (.clk(clk), .sys_rst(sys_rst),
   .mgmt_req(mgmt_req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
   .vendor_access_q(vendor_access_q), .core_status(core_status),
   .core_ctrl_q(core_ctrl_q), .rx_oe_q(rx_oe_q), .link_pass_q(link_pass_q),
   .vendor_gate_strap(vendor_gate_strap));

// >>> testbench/mgmt_station.sv
// management station model issuing register accesses
`timescale 1ns/1ps
module mgmt_station (
   input wire logic clk,
   output phy_regs_pkg::mgmt_req_t mgmt_req,
   input wire logic [15:0] rd_data_q,
   input wire logic vendor_access_q
);
   // idle request at time zero
   initial begin
      mgmt_req = '0;
   end
   // one write cycle, then idle
   task automatic write(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      mgmt_req <= '{rd: 1'h0, wr: 1'h1, addr: a, wdata: d};
      @(posedge clk);
      mgmt_req <= '0;
   endtask
   // one read cycle; answer taken at the edge that closes the answer cycle
   task automatic read(input logic [4:0] a, output logic [15:0] d, output logic va);
      @(posedge clk);
      mgmt_req <= '{rd: 1'h1, wr: 1'h0, addr: a, wdata: 16'h0000};
      @(posedge clk);
      mgmt_req <= '0;
      @(posedge clk);
      d = rd_data_q;
      va = vendor_access_q;
   endtask
endmodule

// >>> testbench/phy_status_ops_regs_tb.sv
// self-checking bench for the status and operations register bank
`timescale 1ns/1ps
module phy_status_ops_regs_tb;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   phy_regs_pkg::mgmt_req_t mgmt_req;
   phy_regs_pkg::core_status_t cs = '0;
   phy_regs_pkg::core_ctrl_t core_ctrl_q;
   logic [15:0] rd_data_q, d;
   logic rd_valid_q, vendor_access_q, rx_dv_out_q, rx_oe_q, link_pass_q, va;
   logic [3:0] rxd_out_q;
   logic [1:0] mode_strap = 2'h3;
   logic amdix_strap = 1'h1, receive_tristate_strap = 1'h1, gate_strap = 1'h1;
   logic [3:0] rxd_in = 4'h5;
   logic rx_dv_in = 1'h0;
   logic [15:0] st_exp [4] = '{16'h0962, 16'h0802, 16'h0802, 16'h0800};
   int n_fail = 0;
   int n_tests = 0;

   phy_status_ops_regs u_phy_status_ops_regs (.clk(clk), .sys_rst(sys_rst),
      .mgmt_req(mgmt_req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
      .vendor_access_q(vendor_access_q), .core_status(cs), .core_ctrl_q(core_ctrl_q),
      .bus_mode_strap(mode_strap), .amdix_strap(amdix_strap),
      .rx_tristate_strap(receive_tristate_strap), .vendor_gate_strap(gate_strap),
      .rx_data_core(rxd_in), .rx_dv_core(rx_dv_in), .rxd_out_q(rxd_out_q),
      .rx_dv_out_q(rx_dv_out_q), .rx_oe_q(rx_oe_q), .link_pass_q(link_pass_q));
   mgmt_station u_mgmt_station (.clk(clk), .mgmt_req(mgmt_req), .rd_data_q(rd_data_q),
      .vendor_access_q(vendor_access_q));

   // 100 ns clock
   initial begin
      forever #50 clk = ~clk;
   end
   // compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // write operations word, then check controls two cycles on
   task automatic ops(input logic [15:0] w, input logic [15:0] rb, input logic [15:0] ctl);
      u_mgmt_station.write(5'h12, w);
      @(posedge clk);
      #1;
      check(16'(core_ctrl_q), ctl);
      check(16'(rx_oe_q), 16'(!w[10]));
      check(16'(link_pass_q), 16'(w[1]));
      u_mgmt_station.read(5'h12, d, va);
      check(d, rb);
      u_mgmt_station.read(5'h19, d, va);
      check(16'(va), 16'(!w[9]));
   endtask

   // watchdog
   initial begin
      #(3000 * 100);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end
   // test sequence
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'h0;
      mode_strap <= 2'h1; // straps only count during reset
      u_mgmt_station.read(5'h12, d, va);
      check(d, 16'h2E10);
      check(16'(rx_oe_q), 16'h0000);
      u_mgmt_station.read(5'h19, d, va);
      check(d, 16'h0000);
      check(16'(va), 16'h0000);
      $display("reset image done");
      ops(16'hFFFF, 16'h2F3F, 16'h0064);
      ops(16'h0000, 16'h2010, 16'h001B);
      $display("operations done");
      @(posedge clk);
      cs <= '{an_progress: 3'h1, false_carrier: 1'h1, halt_symbol: 1'h1,
         premature_end: 1'h1, remote_fault: 1'h1, default: 1'h0};
      @(posedge clk);
      cs <= '{an_progress: 3'h1, remote_fault: 1'h1, default: 1'h0};
      for (int i = 0; i < 4; i++) begin
         if (i == 2) begin
            cs.remote_fault <= 1'h0;
         end
         u_mgmt_station.read(5'h11, d, va);
         check(d, st_exp[i]);
      end
      $display("latched flags done");
      cs.link_valid <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         if (i == 2) begin
            @(posedge clk);
            cs.link_valid <= 1'h0;
            @(posedge clk);
            cs.link_valid <= 1'h1;
         end
         u_mgmt_station.read(5'h11, d, va);
         check(d, 16'h0800 | 16'(i % 2));
      end
      check(16'(link_pass_q), 16'h0001);
      $display("link status done");
      // receive path copies the core data one cycle late
      rxd_in <= 4'hA;
      rx_dv_in <= 1'h1;
      repeat (2) @(posedge clk);
      check(16'(rxd_out_q), 16'h000A);
      check(16'(rx_dv_out_q), 16'h0001);
      $display("receive path done");
      // mid-run resets recapture serial, then mii bus mode
      for (int m = 1; m >= 0; m--) begin
         mode_strap <= 2'(m);
         sys_rst <= 1'h1;
         repeat (2) @(posedge clk);
         sys_rst <= 1'h0;
         u_mgmt_station.read(5'h12, d, va);
         check(d, 16'h0E10 | 16'(m << 12));
         check(16'(rx_oe_q), 16'h0000);
      end
      $display("strap recapture done");
      conclude();
   end
endmodule
